// [hdl/fps_sequencer.sv]
// Purpose: Drives the flash control register bits and byte port to
//          program one 32-byte unit or erase one block, with timed waits
// Assumes: Flash returns read data on the cycle after mem_req.rd
// Notes:   Software drives it over Avalon-MM; one interrupt output
`timescale 1ns/100ps
`include "fps_regs.svh"

// What this block does
// - Wait 10 us after setting write enable
// - Wait 50 us after program setup
// - Pulse 150 us attempts 1-4, else 500
// - Wait 10 us after clearing program pulse
// - Wait 10 us after clearing program setup
// - Wait 4 us after setting program verify
// - Dummy write ff, wait 2 us, read
// - Wait 4 us after clearing program verify
// - At most 403 program attempts per unit
// - 32-byte units; time counts pulse only
// - Wait 200 us after erase setup
// - Erase pulse lasts 5 to 10 ms
// - Wait 10 us after clearing erase pulse
// - Wait 10 us after clearing erase setup
// - Wait 20 us after setting erase verify
// - Wait 5 us after clearing erase verify
// - Erase limit times pulse gives maximum
module fps_sequencer #(
   parameter int PULSE_LONG_CYC  = `FPS_T_PLONG_US * `FPS_CLK_MHZ,
   parameter int ERASE_PULSE_CYC = `FPS_T_EPULSE_US * `FPS_CLK_MHZ,
   parameter int ERASE_MAX       = `FPS_ERASE_MAX,
   parameter int BLOCK_BYTES     = `FPS_BLOCK_BYTES
) (
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   // Avalon-MM slave
   input  wire logic [3:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [3:0]           avs_byteenable,
   input  wire logic [31:0]          avs_writedata,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   // Interrupt
   output logic                      irq,
   // Flash control register bits and byte port
   output fps_pkg::fps_ctrl_t        flash_ctrl,
   output fps_pkg::fps_mem_req_t     mem_req,
   input  wire logic [7:0]           mem_rdata
);

   localparam int IDX_N  = (BLOCK_BYTES > `FPS_UNIT_BYTES) ?
                           BLOCK_BYTES : `FPS_UNIT_BYTES;
   localparam int IDX_W  = $clog2(IDX_N);
   localparam int TMR_W  = $clog2(ERASE_PULSE_CYC + PULSE_LONG_CYC + 1);
   localparam int ATT_W  = 9;
   localparam int AW     = `FPS_FLASH_AW;

   typedef enum logic [13:0] {
      FPS_IDLE   = 14'h0001,
      FPS_SWE    = 14'h0002,
      FPS_LOAD   = 14'h0004,
      FPS_SETUP  = 14'h0008,
      FPS_PULSE  = 14'h0010,
      FPS_POFF   = 14'h0020,
      FPS_SUOFF  = 14'h0040,
      FPS_VSET   = 14'h0080,
      FPS_DUMMY  = 14'h0100,
      FPS_DWAIT  = 14'h0200,
      FPS_READ   = 14'h0400,
      FPS_CHECK  = 14'h0800,
      FPS_VOFF   = 14'h1000,
      FPS_SPARE  = 14'h2000
   } fps_state_t;

   fps_state_t        state;
   logic [TMR_W-1:0]  timer;
   logic [IDX_W-1:0]  idx;
   logic [ATT_W-1:0]  attempts;
   logic [31:0]       pulse_time;
   logic [AW-1:0]     base_addr;
   logic              erase_mode;
   logic              mismatch;
   logic              last_fail;
   logic              abort_req;
   logic [1:0]        irq_status;
   logic [1:0]        irq_mask;
   logic              rd_pend;
   logic              ev_done;
   logic              ev_fail;
   logic [7:0]        orig_buf   [`FPS_UNIT_BYTES];
   logic [7:0]        reprog_buf [`FPS_UNIT_BYTES];

   logic              busy;
   logic              wr_ctrl;
   logic              start_prog;
   logic              start_erase;
   logic              byte_bad;
   logic              last_byte;
   logic              retry_ok;
   logic [ATT_W-1:0]  att_limit;
   logic [TMR_W-1:0]  pulse_len;

   assign busy        = (state != FPS_IDLE);
   assign wr_ctrl     = avs_write && (avs_address == `FPS_REG_CTRL);
   // Starts are ignored while a sequence runs
   assign start_prog  = wr_ctrl && !busy && avs_byteenable[0] &&
                        avs_writedata[`FPS_CTRL_PROG];
   assign start_erase = wr_ctrl && !busy && avs_byteenable[0] &&
                        !avs_writedata[`FPS_CTRL_PROG] &&
                        avs_writedata[`FPS_CTRL_ERASE];

   // Erase verify expects the erased pattern, program verify the data
   assign byte_bad  = erase_mode ?
                      (mem_rdata != `FPS_VERIFY_BYTE) :
                      (mem_rdata != orig_buf[idx[4:0]]);
   assign last_byte = erase_mode ?
                      (idx == IDX_W'(BLOCK_BYTES - 1)) :
                      (idx == IDX_W'(`FPS_UNIT_BYTES - 1));
   assign att_limit = erase_mode ? ATT_W'(ERASE_MAX) :
                                   ATT_W'(`FPS_PROG_MAX);
   assign retry_ok  = (attempts < att_limit) && !abort_req;

   // Count already includes the pulse about to start
   assign pulse_len = erase_mode ? TMR_W'(ERASE_PULSE_CYC) :
                      (attempts <= ATT_W'(`FPS_PROG_SHORT_N)) ?
                      TMR_W'(`FPS_CYC_PSHORT) :
                      TMR_W'(PULSE_LONG_CYC);

   // Sequence engine: the timer holds each step for at least its wait
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state      <= FPS_IDLE;
         timer      <= '0;
         idx        <= '0;
         attempts   <= '0;
         erase_mode <= 1'b0;
         mismatch   <= 1'b0;
         last_fail  <= 1'b0;
         flash_ctrl <= '0;
         mem_req    <= '0;
         ev_done    <= 1'b0;
         ev_fail    <= 1'b0;
      end else begin
         mem_req.wr <= 1'b0;
         mem_req.rd <= 1'b0;
         ev_done    <= 1'b0;
         ev_fail    <= 1'b0;
         if (timer != '0) begin
            timer <= timer - TMR_W'(1);
         end
         case (state)
            FPS_IDLE: begin
               if (start_prog || start_erase) begin
                  erase_mode <= start_erase;
                  attempts   <= '0;
                  idx        <= '0;
                  last_fail  <= 1'b0;
                  flash_ctrl.software_write_enable <= 1'b1;
                  timer      <= TMR_W'(`FPS_CYC_SWE);
                  state      <= FPS_SWE;
               end
            end
            FPS_SWE: begin
               if (timer == '0) begin
                  if (erase_mode) begin
                     flash_ctrl.erase_setup <= 1'b1;
                     timer    <= TMR_W'(`FPS_CYC_ESU);
                     attempts <= attempts + ATT_W'(1);
                     state    <= FPS_SETUP;
                  end else begin
                     idx   <= '0;
                     state <= FPS_LOAD;
                  end
               end
            end
            // Latch the 32 bytes (reprogram data on retries)
            FPS_LOAD: begin
               mem_req.wr    <= 1'b1;
               mem_req.addr  <= base_addr + AW'(idx);
               mem_req.wdata <= reprog_buf[idx[4:0]];
               idx           <= idx + IDX_W'(1);
               if (last_byte) begin
                  flash_ctrl.program_setup <= 1'b1;
                  timer    <= TMR_W'(`FPS_CYC_PSU);
                  attempts <= attempts + ATT_W'(1);
                  state    <= FPS_SETUP;
               end
            end
            FPS_SETUP: begin
               if (timer == '0) begin
                  flash_ctrl.program_pulse <= !erase_mode;
                  flash_ctrl.erase_pulse   <= erase_mode;
                  timer <= pulse_len;
                  state <= FPS_PULSE;
               end
            end
            FPS_PULSE: begin
               if (timer == '0) begin
                  flash_ctrl.program_pulse <= 1'b0;
                  flash_ctrl.erase_pulse   <= 1'b0;
                  timer <= erase_mode ?
                           TMR_W'(`FPS_CYC_EOFF) :
                           TMR_W'(`FPS_CYC_POFF);
                  state <= FPS_POFF;
               end
            end
            FPS_POFF: begin
               if (timer == '0) begin
                  flash_ctrl.program_setup <= 1'b0;
                  flash_ctrl.erase_setup   <= 1'b0;
                  timer <= erase_mode ?
                           TMR_W'(`FPS_CYC_ESUOFF) :
                           TMR_W'(`FPS_CYC_PSUOFF);
                  state <= FPS_SUOFF;
               end
            end
            FPS_SUOFF: begin
               if (timer == '0) begin
                  flash_ctrl.program_verify <= !erase_mode;
                  flash_ctrl.erase_verify   <= erase_mode;
                  timer    <= erase_mode ?
                              TMR_W'(`FPS_CYC_EV) :
                              TMR_W'(`FPS_CYC_PV);
                  idx      <= '0;
                  mismatch <= 1'b0;
                  state    <= FPS_VSET;
               end
            end
            FPS_VSET: begin
               if (timer == '0) begin
                  state <= FPS_DUMMY;
               end
            end
            FPS_DUMMY: begin
               mem_req.wr    <= 1'b1;
               mem_req.addr  <= base_addr + AW'(idx);
               mem_req.wdata <= `FPS_VERIFY_BYTE;
               timer         <= TMR_W'(`FPS_CYC_DUMMY);
               state         <= FPS_DWAIT;
            end
            FPS_DWAIT: begin
               if (timer == '0) begin
                  mem_req.rd <= 1'b1;
                  state      <= FPS_READ;
               end
            end
            FPS_READ: state <= FPS_CHECK;
            // Erase verify stops at the first byte still programmed
            FPS_CHECK: begin
               mismatch <= mismatch || byte_bad;
               if (last_byte || (erase_mode && byte_bad)) begin
                  flash_ctrl.program_verify <= 1'b0;
                  flash_ctrl.erase_verify   <= 1'b0;
                  timer <= erase_mode ?
                           TMR_W'(`FPS_CYC_EVOFF) :
                           TMR_W'(`FPS_CYC_PVOFF);
                  state <= FPS_VOFF;
               end else begin
                  idx   <= idx + IDX_W'(1);
                  state <= FPS_DUMMY;
               end
            end
            FPS_VOFF: begin
               if (timer == '0) begin
                  if (!mismatch) begin
                     flash_ctrl.software_write_enable <= 1'b0;
                     ev_done <= 1'b1;
                     state   <= FPS_IDLE;
                  end else if (!retry_ok) begin
                     flash_ctrl.software_write_enable <= 1'b0;
                     last_fail <= 1'b1;
                     ev_fail   <= 1'b1;
                     state     <= FPS_IDLE;
                  end else if (erase_mode) begin
                     flash_ctrl.erase_setup <= 1'b1;
                     timer    <= TMR_W'(`FPS_CYC_ESU);
                     attempts <= attempts + ATT_W'(1);
                     state    <= FPS_SETUP;
                  end else begin
                     idx   <= '0;
                     state <= FPS_LOAD;
                  end
               end
            end
            default: begin
               flash_ctrl <= '0;
               state      <= FPS_IDLE;
            end
         endcase
      end
   end

   // Time with the pulse bit set, verification excluded
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pulse_time <= '0;
      end else if (start_prog || start_erase) begin
         pulse_time <= '0;
      end else if (flash_ctrl.program_pulse || flash_ctrl.erase_pulse) begin
         pulse_time <= pulse_time + 32'h0000_0001;
      end
   end

   // Abort is honoured only at the retry decision, so no wait is cut
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         abort_req <= 1'b0;
      end else if (!busy) begin
         abort_req <= 1'b0;
      end else if (wr_ctrl && avs_byteenable[0] &&
                   avs_writedata[`FPS_CTRL_ABORT]) begin
         abort_req <= 1'b1;
      end
   end

   // Target address, frozen while busy
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         base_addr <= '0;
      end else if (avs_write && !busy &&
                   avs_address == `FPS_REG_ADDR) begin
         base_addr <= avs_writedata[AW-1:0];
      end
   end

   // Data and reprogram buffers, one byte per entry
   genvar gi;
   generate
      for (gi = 0; gi < `FPS_UNIT_BYTES; gi++) begin : g_byte
         localparam logic [2:0] WORD = 3'(gi / 4);
         localparam int         LANE = gi % 4;
         always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               orig_buf[gi]   <= 8'hff;
               reprog_buf[gi] <= 8'hff;
            end else begin
               if (avs_write && !busy &&
                   avs_address[`FPS_REG_DATA_BIT] &&
                   avs_address[2:0] == WORD &&
                   avs_byteenable[LANE]) begin
                  orig_buf[gi] <= avs_writedata[8*LANE +: 8];
               end
               if (start_prog) begin
                  reprog_buf[gi] <= orig_buf[gi];
               end else if (state == FPS_CHECK && !erase_mode &&
                            idx == IDX_W'(gi)) begin
                  // Only bits still reading one get another pulse
                  reprog_buf[gi] <= orig_buf[gi] | ~mem_rdata;
               end
            end
         end
      end
   endgenerate

   // Interrupt status: set wins over a write-one clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_status <= '0;
         irq_mask   <= '0;
      end else begin
         if (avs_write && avs_address == `FPS_REG_IRQ_MASK &&
             avs_byteenable[0]) begin
            irq_mask <= avs_writedata[1:0];
         end
         if (avs_write && avs_address == `FPS_REG_IRQ_ST &&
             avs_byteenable[0]) begin
            irq_status[`FPS_IRQ_DONE] <=
               (irq_status[`FPS_IRQ_DONE] &
                ~avs_writedata[`FPS_IRQ_DONE]) | ev_done;
            irq_status[`FPS_IRQ_FAIL] <=
               (irq_status[`FPS_IRQ_FAIL] &
                ~avs_writedata[`FPS_IRQ_FAIL]) | ev_fail;
         end else begin
            irq_status[`FPS_IRQ_DONE] <= irq_status[`FPS_IRQ_DONE] | ev_done;
            irq_status[`FPS_IRQ_FAIL] <= irq_status[`FPS_IRQ_FAIL] | ev_fail;
         end
      end
   end

   assign irq = |(irq_status & irq_mask);

   // Reads take one wait cycle; writes complete at once
   assign avs_waitrequest = avs_read && !rd_pend;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rd_pend      <= 1'b0;
         avs_readdata <= '0;
      end else begin
         rd_pend <= avs_read && !rd_pend;
         if (avs_read && !rd_pend) begin
            avs_readdata <= '0;
            if (avs_address[`FPS_REG_DATA_BIT]) begin
               avs_readdata <= {orig_buf[{avs_address[2:0], 2'h3}],
                                orig_buf[{avs_address[2:0], 2'h2}],
                                orig_buf[{avs_address[2:0], 2'h1}],
                                orig_buf[{avs_address[2:0], 2'h0}]};
            end else begin
               case (avs_address)
                  `FPS_REG_STATUS: begin
                     avs_readdata[`FPS_ST_BUSY]  <= busy;
                     avs_readdata[`FPS_ST_FAIL]  <= last_fail;
                     avs_readdata[`FPS_ST_ERASE] <= erase_mode;
                  end
                  `FPS_REG_ADDR:     avs_readdata[AW-1:0] <= base_addr;
                  `FPS_REG_ATTEMPTS: avs_readdata[ATT_W-1:0] <= attempts;
                  `FPS_REG_PTIME:    avs_readdata <= pulse_time;
                  `FPS_REG_IRQ_ST:   avs_readdata[1:0] <= irq_status;
                  `FPS_REG_IRQ_MASK: avs_readdata[1:0] <= irq_mask;
                  default: avs_readdata <= '0;
               endcase
            end
         end
      end
   end

endmodule : fps_sequencer

// [hdl/fps_regs.svh]
// Purpose: Named constants for the flash program/erase sequencer
// Assumes: 20 MHz reference clock; byte-wide on-chip flash port
// Notes:   Times are kept in their own unit, cycle counts derive from them
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH

// Clock rate in cycles per microsecond
`define FPS_CLK_MHZ        20

// Wait times, microseconds
`define FPS_T_SWE_US       10
`define FPS_T_PSU_US       50
`define FPS_T_PSHORT_US    150
`define FPS_T_PLONG_US     500
`define FPS_T_POFF_US      10
`define FPS_T_PSUOFF_US    10
`define FPS_T_PV_US        4
`define FPS_T_DUMMY_US     2
`define FPS_T_PVOFF_US     4
`define FPS_T_ESU_US       200
`define FPS_T_EPULSE_US    10000
`define FPS_T_EOFF_US      10
`define FPS_T_ESUOFF_US    10
`define FPS_T_EV_US        20
`define FPS_T_EVOFF_US     5

// Derived cycle counts (least times, exact at 20 MHz)
`define FPS_CYC_SWE        (`FPS_T_SWE_US * `FPS_CLK_MHZ)
`define FPS_CYC_PSU        (`FPS_T_PSU_US * `FPS_CLK_MHZ)
`define FPS_CYC_PSHORT     (`FPS_T_PSHORT_US * `FPS_CLK_MHZ)
`define FPS_CYC_POFF       (`FPS_T_POFF_US * `FPS_CLK_MHZ)
`define FPS_CYC_PSUOFF     (`FPS_T_PSUOFF_US * `FPS_CLK_MHZ)
`define FPS_CYC_PV         (`FPS_T_PV_US * `FPS_CLK_MHZ)
`define FPS_CYC_DUMMY      (`FPS_T_DUMMY_US * `FPS_CLK_MHZ)
`define FPS_CYC_PVOFF      (`FPS_T_PVOFF_US * `FPS_CLK_MHZ)
`define FPS_CYC_ESU        (`FPS_T_ESU_US * `FPS_CLK_MHZ)
`define FPS_CYC_EOFF       (`FPS_T_EOFF_US * `FPS_CLK_MHZ)
`define FPS_CYC_ESUOFF     (`FPS_T_ESUOFF_US * `FPS_CLK_MHZ)
`define FPS_CYC_EV         (`FPS_T_EV_US * `FPS_CLK_MHZ)
`define FPS_CYC_EVOFF      (`FPS_T_EVOFF_US * `FPS_CLK_MHZ)

// Sequence limits
`define FPS_UNIT_BYTES     32
`define FPS_PROG_SHORT_N   4
`define FPS_PROG_MAX       403
`define FPS_ERASE_MAX      30
`define FPS_BLOCK_BYTES    1024
`define FPS_VERIFY_BYTE    8'hff
`define FPS_FLASH_AW       16

// Register word offsets
`define FPS_REG_CTRL       4'h0
`define FPS_REG_STATUS     4'h1
`define FPS_REG_ADDR       4'h2
`define FPS_REG_ATTEMPTS   4'h3
`define FPS_REG_PTIME      4'h4
`define FPS_REG_IRQ_ST     4'h5
`define FPS_REG_IRQ_MASK   4'h6
`define FPS_REG_DATA_BIT   3

// Field positions
`define FPS_CTRL_PROG      0
`define FPS_CTRL_ERASE     1
`define FPS_CTRL_ABORT     2
`define FPS_ST_BUSY        0
`define FPS_ST_FAIL        1
`define FPS_ST_ERASE       2
`define FPS_IRQ_DONE       0
`define FPS_IRQ_FAIL       1

`endif

// [hdl/fps_pkg.sv]
// Purpose: Types shared by the flash program/erase sequencer
// Assumes: Constants come from fps_regs.svh
// Notes:   Structs carry the flash control bits and the byte port
`include "fps_regs.svh"
package fps_pkg;

   typedef struct packed {
      logic software_write_enable;
      logic program_setup;
      logic program_pulse;
      logic program_verify;
      logic erase_setup;
      logic erase_pulse;
      logic erase_verify;
   } fps_ctrl_t;

   typedef struct packed {
      logic                     wr;
      logic                     rd;
      logic [`FPS_FLASH_AW-1:0] addr;
      logic [7:0]               wdata;
   } fps_mem_req_t;

endpackage : fps_pkg

// [verif/fps_seq_props.sv]
// Purpose: Timing checks on the flash control bits and byte port
// Assumes: Bound to fps_sequencer, one clock domain
// Notes:   held = cycles the previous control value stood
`timescale 1ns/100ps
module fps_seq_props #(
   parameter int PULSE_LONG_CYC  = 10000,
   parameter int ERASE_PULSE_CYC = 200000
) (
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  rst,
   // Flash side
   input wire fps_pkg::fps_ctrl_t    flash_ctrl,
   input wire fps_pkg::fps_mem_req_t mem_req
);
   fps_pkg::fps_ctrl_t prev;
   int                 held;
   int                 swe_age;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         prev <= '0;
         held <= 0;
         swe_age <= 0;
      end else begin
         prev <= flash_ctrl;
         held <= (flash_ctrl != prev) ? 1 : held + 1;
         swe_age <= (flash_ctrl.software_write_enable &&
                     !prev.software_write_enable) ? 1 : swe_age + 1;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_dummy;
      mem_req.wr && (flash_ctrl.program_verify || flash_ctrl.erase_verify);
   endsequence
   sequence s_setup;
      $rose(flash_ctrl.program_setup) || $rose(flash_ctrl.erase_setup);
   endsequence
   // Equal ages: nothing changed since write enable rose
   property p_swe;
      s_setup ##0 (held == swe_age) |-> held >= 200;
   endproperty
   property p_psu;
      $rose(flash_ctrl.program_pulse) |-> held >= 1000;
   endproperty
   property p_pulse;
      $fell(flash_ctrl.program_pulse)
         |-> held >= 3000 && held <= PULSE_LONG_CYC + 1;
   endproperty
   property p_pv;
      $rose(flash_ctrl.program_verify) || $rose(flash_ctrl.erase_verify)
         |-> held >= 200;
   endproperty
   property p_dummy;
      s_dummy |-> mem_req.wdata == 8'hff ##[40:42] mem_req.rd;
   endproperty
   property p_pv_wr;
      mem_req.wr && flash_ctrl.program_verify |-> held >= 80;
   endproperty
   property p_esu;
      $rose(flash_ctrl.erase_pulse) |-> held >= 4000;
   endproperty
   property p_epulse;
      $fell(flash_ctrl.erase_pulse) |-> held >= ERASE_PULSE_CYC / 2
         && held <= ERASE_PULSE_CYC + 1;
   endproperty
   property p_eoff;
      $fell(flash_ctrl.program_setup) || $fell(flash_ctrl.erase_setup)
         |-> held >= 200;
   endproperty
   property p_ev_wr;
      mem_req.wr && flash_ctrl.erase_verify |-> held >= 400;
   endproperty
   property p_retry;
      s_setup ##0 (held != swe_age)
         |-> held >= (flash_ctrl.erase_setup ? 100 : 80);
   endproperty
   property p_end;
      $fell(flash_ctrl.software_write_enable) |-> flash_ctrl == '0;
   endproperty
   a_swe: assert property (p_swe)
      else $error("setup too soon after write enable");
   a_psu: assert property (p_psu)
      else $error("program pulse too soon");
   a_pulse: assert property (p_pulse)
      else $error("program pulse length wrong");
   a_pv: assert property (p_pv)
      else $error("verify set too soon");
   a_dummy: assert property (p_dummy)
      else $error("dummy write or readback wrong");
   a_pv_wr: assert property (p_pv_wr)
      else $error("program dummy write too soon");
   a_esu: assert property (p_esu)
      else $error("erase pulse too soon");
   a_epulse: assert property (p_epulse)
      else $error("erase pulse length wrong");
   a_eoff: assert property (p_eoff)
      else $error("setup cleared too soon");
   a_ev_wr: assert property (p_ev_wr)
      else $error("erase dummy write too soon");
   a_retry: assert property (p_retry)
      else $error("retry too soon");
   a_end: assert property (p_end)
      else $error("control bits left set at end");
endmodule : fps_seq_props
bind fps_sequencer fps_seq_props #(
   .PULSE_LONG_CYC(PULSE_LONG_CYC),
   .ERASE_PULSE_CYC(ERASE_PULSE_CYC)
) u_props (
   .ref_clk(ref_clk),
   .rst(rst),
   .flash_ctrl(flash_ctrl),
   .mem_req(mem_req)
);

// [verif/fps_flash_model.sv]
// Purpose: Behavioural flash array behind the control bits
// Assumes: Programming only clears bits; erase sets a byte to ff
// Notes:   stuck keeps one byte from erasing, to force a retry
`timescale 1ns/100ps
module fps_flash_model (
   // Clock and reset
   input wire logic                  ref_clk,
   input wire logic                  rst,
   // Sequencer side
   input wire fps_pkg::fps_ctrl_t    flash_ctrl,
   input wire fps_pkg::fps_mem_req_t mem_req,
   input wire logic                  stuck,
   output logic [7:0]                mem_rdata
);
   logic [7:0] mem [256];
   logic [7:0] pbuf [256];
   logic       p_q;
   logic       e_q;
   initial for (int i = 0; i < 256; i++) begin
      mem[i] = 8'hff;
      pbuf[i] = 8'hff;
   end
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mem_rdata <= 8'h00;
         p_q <= 1'b0;
         e_q <= 1'b0;
      end else begin
         p_q <= flash_ctrl.program_pulse;
         e_q <= flash_ctrl.erase_pulse;
         if (mem_req.wr && !flash_ctrl.program_verify &&
             !flash_ctrl.erase_verify)
            pbuf[mem_req.addr[7:0]] <= mem_req.wdata;
         for (int i = 0; i < 256; i++) begin
            if (flash_ctrl.program_pulse && !p_q) begin
               mem[i] <= mem[i] & pbuf[i];
               pbuf[i] <= 8'hff;
            end
            if (flash_ctrl.erase_pulse && !e_q)
               mem[i] <= (stuck && i == 8'h45) ? 8'h00 : 8'hff;
         end
         // Idle port flips to the inverse of its last value every cycle, so a stale byte never holds
         mem_rdata <= mem_req.rd ? mem[mem_req.addr[7:0]] : ~mem_rdata;
      end
   end
endmodule : fps_flash_model

// [verif/tb_flash_program_erase_sequencer.sv]
// Purpose: Register-level tests of the flash sequencer
// Assumes: Short erase pulse, two erase attempts, 32-byte block
// Notes:   Waitrequest is sampled at the rising edge
`timescale 1ns/100ps
`include "fps_regs.svh"
module tb_flash_program_erase_sequencer;
   logic ref_clk = 0, rst = 1, avs_read = 0, avs_write = 0, stuck = 0;
   logic [3:0]            avs_address = '0;
   logic [31:0]           avs_writedata = '0, avs_readdata, rdq;
   logic                  avs_waitrequest, irq;
   logic [7:0]            mem_rdata;
   fps_pkg::fps_ctrl_t    flash_ctrl;
   fps_pkg::fps_mem_req_t mem_req;
   int                    n_fail = 0, checks_done = 0;
   initial forever #25 ref_clk = ~ref_clk;
   fps_sequencer #(.ERASE_PULSE_CYC(100), .ERASE_MAX(2), .BLOCK_BYTES(32))
      dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
           .avs_read(avs_read), .avs_write(avs_write),
           .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
           .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
           .irq(irq), .flash_ctrl(flash_ctrl), .mem_req(mem_req),
           .mem_rdata(mem_rdata));
   fps_flash_model flash (.ref_clk(ref_clk), .rst(rst), .stuck(stuck),
      .flash_ctrl(flash_ctrl), .mem_req(mem_req), .mem_rdata(mem_rdata));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      rdq = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus
   task automatic rdc(input logic [3:0] a, input logic [31:0] e, string n);
      bus(1'b0, a, 32'h0);
      chk(n, rdq, e);
   endtask : rdc
   task automatic run(input logic [31:0] cmd);
      bus(1'b1, `FPS_REG_CTRL, cmd);
      rdq = 32'h1;
      while (rdq[`FPS_ST_BUSY]) bus(1'b0, `FPS_REG_STATUS, 32'h0);
   endtask : run
   task automatic print_verdict;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      rdc(`FPS_REG_STATUS, 32'h0, "status");
      bus(1'b1, 4'h7, 32'hffffffff);
      rdc(4'h7, 32'h0, "unmapped");
      bus(1'b1, `FPS_REG_IRQ_MASK, 32'h3);
      rdc(`FPS_REG_IRQ_MASK, 32'h3, "mask");
      $display("test regs done");
      bus(1'b1, `FPS_REG_ADDR, 32'h40);
      for (int n = 0; n < 8; n++)
         bus(1'b1, 4'(8 + n), 32'h03020100 + n * 32'h04040404);
      run(32'h1);
      rdc(`FPS_REG_STATUS, 32'h0, "prog status");
      rdc(`FPS_REG_ATTEMPTS, 32'h1, "attempts");
      rdc(`FPS_REG_PTIME, 32'd3001, "pulse time");
      for (int i = 0; i < 32; i++)
         chk("cell", 32'(flash.mem[8'h40 + i]), 32'(i));
      rdc(`FPS_REG_IRQ_ST, 32'h1, "done flag");
      chk("irq on", 32'(irq), 32'h1);
      bus(1'b1, `FPS_REG_IRQ_ST, 32'h1);
      @(posedge ref_clk);
      chk("irq off", 32'(irq), 32'h0);
      $display("test program done");
      stuck <= 1'b1;
      run(32'h2);
      chk("fail bit", 32'(rdq[`FPS_ST_FAIL]), 32'h1);
      rdc(`FPS_REG_ATTEMPTS, 32'h2, "erase tries");
      rdc(`FPS_REG_IRQ_ST, 32'h2, "fail flag");
      bus(1'b1, `FPS_REG_CTRL, 32'h2);
      run(32'h4);
      rdc(`FPS_REG_ATTEMPTS, 32'h1, "aborted");
      bus(1'b1, `FPS_REG_IRQ_ST, 32'h3);
      $display("test erase fail done");
      stuck <= 1'b0;
      run(32'h2);
      chk("pass bit", 32'(rdq[`FPS_ST_FAIL]), 32'h0);
      rdc(`FPS_REG_ATTEMPTS, 32'h1, "erase once");
      for (int i = 0; i < 32; i++)
         chk("erased", 32'(flash.mem[8'h40 + i]), 32'hff);
      $display("test erase done");
      print_verdict;
   end
   initial begin
      repeat (80000) @(posedge ref_clk);
      n_fail++;
      print_verdict;
   end
endmodule : tb_flash_program_erase_sequencer
